// ===== dv/cntarr_checker.sv
// Port-level assertions for the counter array
`timescale 1ns/1ps
`default_nettype none
module cntarr_checker #(
    parameter int NUM_MOD = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System and pins
    input wire logic wdt_reset,
    input wire logic ext_count_claimed,
    input wire logic [NUM_MOD-1:0] module_pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_wr_blocked: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("no bvalid");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no rvalid");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && !s_axi_arready) else $error("rvalid dropped");
    a_wdt_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog pulse too long");
    // Pin claims move only on register writes
    a_claim_quiet: assert property ($changed(ext_count_claimed) |->
        $rose(s_axi_bvalid)) else $error("claim moved without write");
    a_oe_quiet: assert property ($changed(module_pin_oe) |->
        $rose(s_axi_bvalid)) else $error("pin enable moved without write");
    c_wdt: cover property (wdt_reset);
    c_claim: cover property ($rose(ext_count_claimed));
    c_oe: cover property ($rose(module_pin_oe[0]));
endmodule
bind cntarr_top cntarr_checker #(.NUM_MOD(NUM_MOD)) i_chk (.*);
`default_nettype wire

// ===== dv/cntarr_pins.sv
// Model of the signals outside the counter array pins
`timescale 1ns/1ps
`default_nettype none
module cntarr_pins (
    // Clock
    input wire logic aclk,
    // Pins
    output logic ext_count_input,
    output logic [4:0] module_pin_in
);
    initial begin
        ext_count_input = 1'h1;
        module_pin_in = 5'h1F;
    end
    // Edges no faster than a quarter of the clock
    task automatic ext_edges(int n);
        repeat (n) begin
            @(posedge aclk);
            ext_count_input <= 1'h0;
            repeat (4) @(posedge aclk);
            ext_count_input <= 1'h1;
            repeat (4) @(posedge aclk);
        end
    endtask
    task automatic set_pin(int i, logic v);
        @(posedge aclk);
        module_pin_in[i] <= v;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the counter array
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cntarr_pkg::*;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_CNT = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [31:0] RUN = 32'h0000_0100;
    logic aclk = 1'h0, aresetn = 1'h0, idle_mode = 1'h0, timer0_ovf = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    cntarr_word_t s_axi_wdata = '0, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, wdt_reset, ext_count_claimed, ext_count_input;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [4:0] module_pin_in, module_pin_out, module_pin_oe;
    int n_errors = 0, num_checks = 0, n_wdt = 0;
    cntarr_top i_dut (.*);
    cntarr_pins i_pins (.*);
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) begin
        if (wdt_reset === 1'h1) n_wdt++;
    end
    task automatic chk(string s, logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bound(int k);
        if (k >= 50) begin
            chk("bus wait", 1, 0);
            test_done();
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        int k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && k < 50);
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
        bound(k);
    endtask
    task automatic rd(logic [7:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && k < 50);
        s_axi_rready <= 1'h0;
        got = s_axi_rdata;
        resp = s_axi_rresp;
        bound(k);
    endtask
    task automatic rc(string s, logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(s, e, got);
    endtask
    task automatic pulse(int n);
        repeat (n) begin
            @(posedge aclk);
            timer0_ovf <= 1'h1;
            @(posedge aclk);
            timer0_ovf <= 1'h0;
        end
        repeat (4) @(posedge aclk);
    endtask
    task automatic t_regs();
        rc("status reset", A_STAT, 12'h01F);
        wr(A_MODE, 32'hFFFF_FFFF);
        rc("mode bits", A_MODE, 8'hC7);
        chk("ext claimed", 1, ext_count_claimed);
        wr(A_MODE, 0);
        wr(8'h10, 1);
        chk("unmapped wr", 2'h2, resp);
        rc("unmapped rd", 8'h10, 0);
    endtask
    task automatic t_count();
        wr(A_MODE, 8'h84);
        pulse(3);
        rc("stopped", A_CNT, 0);
        wr(A_CTRL, RUN);
        pulse(3);
        rc("timer0 count", A_CNT, 3);
        @(posedge aclk);
        idle_mode <= 1'h1;
        pulse(2);
        rc("idle stop", A_CNT, 3);
        wr(A_MODE, 8'h04);
        pulse(2);
        rc("idle run", A_CNT, 5);
        idle_mode <= 1'h0;
    endtask
    task automatic t_rate(logic [7:0] m, int lo, hi);
        wr(A_CTRL, 0);
        wr(A_CNT, 0);
        wr(A_MODE, m);
        wr(A_CTRL, RUN);
        if (m == 8'h06) i_pins.ext_edges(4);
        else repeat (60) @(posedge aclk);
        repeat (6) @(posedge aclk);
        wr(A_CTRL, 0);
        rd(A_CNT);
        chk("rate count", 1, got >= lo && got <= hi);
    endtask
    task automatic t_ovf();
        wr(A_MODE, 8'h05);
        wr(A_CNT, 16'hFFFF);
        wr(A_CTRL, RUN);
        pulse(1);
        rc("wrap", A_CNT, 0);
        chk("ovf irq", 1, irq);
        pulse(1);
        rc("ovf sticky", A_CTRL, 12'h300);
        wr(A_CTRL, RUN);
        rc("ovf clear", A_CTRL, RUN);
        chk("irq clear", 0, irq);
    endtask
    task automatic t_cmp();
        wr(A_CTRL, 0);
        wr(A_MODE, 8'h04);
        wr(A_CNT, 0);
        wr(8'h40, 5);
        wr(8'h44, 5);
        wr(8'h20, 8'h4D);
        wr(8'h24, 8'h08);
        rc("oe claim", A_STAT, 12'h11F);
        wr(A_CTRL, RUN);
        pulse(5);
        rc("match flag", A_CTRL, 12'h101);
        chk("toggle", 5'h1E, module_pin_out);
        chk("module irq", 1, irq);
        wr(8'h20, 8'h4C);
        @(posedge aclk);
        chk("irq gated", 0, irq);
        wr(A_CTRL, 0);
        wr(8'h20, 0);
        wr(8'h24, 0);
    endtask
    task automatic t_cap();
        wr(A_CNT, 16'h1234);
        wr(8'h28, 8'h20);
        wr(8'h2C, 8'h10);
        i_pins.set_pin(2, 1'h0);
        i_pins.set_pin(3, 1'h0);
        repeat (8) @(posedge aclk);
        rc("fall flag", A_CTRL, 4'h8);
        rc("fall value", 8'h4C, 16'h1234);
        wr(A_CNT, 16'h5678);
        i_pins.set_pin(2, 1'h1);
        i_pins.set_pin(3, 1'h1);
        repeat (8) @(posedge aclk);
        rc("rise value", 8'h48, 16'h5678);
        rc("rise flag", A_CTRL, 4'hC);
        wr(A_CTRL, 0);
    endtask
    task automatic t_pwm();
        wr(8'h44, 16'h8040);
        wr(8'h24, 8'h42);
        wr(A_CNT, 16'h0010);
        wr(A_CTRL, RUN);
        pulse(1);
        chk("pwm low", 0, module_pin_out[1]);
        wr(A_CNT, 16'h00FE);
        pulse(1);
        chk("pwm high", 1, module_pin_out[1]);
        pulse(1);
        chk("pwm reload", 0, module_pin_out[1]);
        rc("reload value", 8'h44, 16'h8080);
        wr(A_CTRL, 0);
        wr(8'h24, 0);
    endtask
    task automatic t_wdt();
        wr(A_MODE, 8'h44);
        wr(A_CNT, 0);
        wr(8'h50, 3);
        wr(8'h30, 8'h40);
        n_wdt = 0;
        wr(A_CTRL, RUN);
        pulse(3);
        chk("wdt reset", 1, n_wdt);
        wr(A_MODE, 8'h04);
        wr(A_CNT, 0);
        pulse(3);
        chk("wdt off", 1, n_wdt);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_count();
        t_rate(8'h02, 34, 36);
        t_rate(8'h00, 10, 11);
        t_rate(8'h06, 4, 4);
        t_ovf();
        t_cmp();
        t_cap();
        t_pwm();
        t_wdt();
        test_done();
    end
endmodule
`default_nettype wire

// ===== verilog/cntarr_ch_if.sv
// Link between the counter core and one compare/capture module
`timescale 1ns/1ps
`default_nettype none
interface cntarr_ch_if;
    import cntarr_pkg::*;
    cntarr_cnt_t cnt;
    logic cnt_upd;
    cntarr_mode_s mode;
    logic cmp_wr;
    cntarr_cnt_t cmp_wdata;
    logic edge_rise;
    logic edge_fall;
    cntarr_cnt_t cmp_val;
    logic hit;
    logic flag_set;
    logic pin_out;
    logic pin_oe;

    modport core (
        output cnt, cnt_upd, mode, cmp_wr, cmp_wdata, edge_rise, edge_fall,
        input cmp_val, hit, flag_set, pin_out, pin_oe
    );
    modport chan (
        input cnt, cnt_upd, mode, cmp_wr, cmp_wdata, edge_rise, edge_fall,
        output cmp_val, hit, flag_set, pin_out, pin_oe
    );
endinterface
`default_nettype wire

// ===== verilog/cntarr_chan.sv
// One compare/capture module of the counter array
`timescale 1ns/1ps
`default_nettype none
`include "cntarr_defs.svh"
module cntarr_chan (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Core link
    cntarr_ch_if.chan bus
);
    import cntarr_pkg::*;

    cntarr_cnt_t cmp_reg, cmp_next;
    logic pin_reg, pin_next;
    logic capture;
    logic wrap;
    cntarr_mode_s m;

    assign m = bus.mode;
    // Fresh counts only, so a stopped counter does not refire
    assign bus.hit = m.comparator_enable & bus.cnt_upd
        & (bus.cnt == cmp_reg);
    assign capture = (bus.edge_rise & m.capture_rise_enable)
        | (bus.edge_fall & m.capture_fall_enable);
    assign bus.flag_set = (bus.hit & m.match_enable) | capture;
    assign wrap = bus.cnt_upd & (bus.cnt[7:0] == 8'h00);

    always_comb begin
        cmp_next = cmp_reg;
        pin_next = pin_reg;
        if (capture) begin
            cmp_next = bus.cnt;
        end else if (bus.cmp_wr) begin
            cmp_next = bus.cmp_wdata;
        end else if (m.pwm_enable && m.comparator_enable && wrap) begin
            cmp_next[7:0] = cmp_reg[15:8];
        end
        if (m.pwm_enable && m.comparator_enable) begin
            pin_next = (bus.cnt[7:0] >= cmp_reg[7:0]);
        end else if (bus.hit && m.toggle_enable) begin
            pin_next = ~pin_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_reg <= 16'h0000;
            pin_reg <= `CNTARR_PIN_RST;
        end else begin
            cmp_reg <= cmp_next;
            pin_reg <= pin_next;
        end
    end

    assign bus.cmp_val = cmp_reg;
    assign bus.pin_out = pin_reg;
    // Pin free for port use unless an output mode owns it
    assign bus.pin_oe = m.comparator_enable
        & (m.toggle_enable | m.pwm_enable);
endmodule
`default_nettype wire

// ===== verilog/cntarr_defs.svh
// Offsets, fields, reset values and counts of the counter array
// Notes on behaviour
// - Time base counts one of four sources
// - Source codes: div6, div2, timer0, external pin
// - One shared counter feeds all five modules
// - Idle-stop bit halts counter during idle
// - Counter advances only while run bit set
// - Overflow sets sticky flag; only software clears
// - Match or capture sets module flag
// - All sources merge into one interrupt line
// - Module interrupt enable gates its flag
// - Toggle mode inverts pin on compare match
// - Match bit lets compare equality set flag
// - Two bits choose falling, rising capture edges
// - Comparator enable gates all compare results
// - Capture copies counter, sets flag
// - Per-module bit enables 8-bit pulse width
// - Only module 4 has watchdog, enable bit
// - Unclaimed pins stay ordinary input/output
// - Pulse output low below compare; wrap reload
// - Watchdog match raises internal reset only
// - Comparator plus match gives software timer
`ifndef CNTARR_DEFS_SVH
`define CNTARR_DEFS_SVH

`define CNTARR_OFF_MODE 8'h00
`define CNTARR_OFF_CTRL 8'h04
`define CNTARR_OFF_COUNT 8'h08
`define CNTARR_OFF_STATUS 8'h0C
`define CNTARR_REGION_MMODE 3'h1
`define CNTARR_REGION_MCMP 3'h2

`define CNTARR_MODE_IDLE 7
`define CNTARR_MODE_WDT 6
`define CNTARR_MODE_SRC_HI 2
`define CNTARR_MODE_SRC_LO 1
`define CNTARR_MODE_OVF_IE 0
`define CNTARR_MODE_MASK 8'hC7
`define CNTARR_MODE_RST 8'h00

`define CNTARR_CTRL_RUN 8
`define CNTARR_CTRL_OVF 9
`define CNTARR_STAT_OE 8
`define CNTARR_STAT_EXT 16

`define CNTARR_SRC_DIV6 2'h0
`define CNTARR_SRC_DIV2 2'h1
`define CNTARR_SRC_TMR0 2'h2
`define CNTARR_SRC_EXT 2'h3
`define CNTARR_DIV6_LAST 3'h5
`define CNTARR_WDT_MOD 4

`define CNTARR_RESP_OKAY 2'h0
`define CNTARR_RESP_SLVERR 2'h2
`define CNTARR_PIN_RST 1'h1

`endif

// ===== verilog/cntarr_pkg.sv
// Types shared by the counter array modules
package cntarr_pkg;

    typedef logic [31:0] cntarr_word_t;
    typedef logic [15:0] cntarr_cnt_t;

    // Per-module mode bits, bit 6 down to bit 0
    typedef struct packed {
        logic comparator_enable;
        logic capture_rise_enable;
        logic capture_fall_enable;
        logic match_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic module_irq_enable;
    } cntarr_mode_s;

endpackage

// ===== verilog/cntarr_sync.sv
// Two-stage synchroniser with edge detection for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module cntarr_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and edges
    input wire logic [W-1:0] din,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_reg, s1_next;
    logic [W-1:0] s2_reg, s2_next;
    logic [W-1:0] s3_reg, s3_next;

    if (W < 1) begin : g_chk
        $error("cntarr_sync: W must be at least 1");
    end

    // Edges come from the later stages
    always_comb begin
        s1_next = din;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Pins idle high: no false edge
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

// ===== verilog/cntarr_top.sv
// Counter array: shared time base, compare/capture modules, AXI4-Lite slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cntarr_defs.svh"
module cntarr_top #(
    parameter int NUM_MOD = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire cntarr_pkg::cntarr_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output cntarr_pkg::cntarr_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System
    input wire logic idle_mode,
    input wire logic timer0_ovf,
    output logic irq,
    output logic wdt_reset,
    // Pins
    input wire logic ext_count_input,
    output logic ext_count_claimed,
    input wire logic [NUM_MOD-1:0] module_pin_in,
    output logic [NUM_MOD-1:0] module_pin_out,
    output logic [NUM_MOD-1:0] module_pin_oe
);
    import cntarr_pkg::*;

    if (NUM_MOD < 5 || NUM_MOD > 8) begin : g_chk
        $error("cntarr_top: NUM_MOD must lie in 5..8");
    end

    function automatic cntarr_word_t merge(cntarr_word_t old, nw,
        logic [3:0] strb);
        cntarr_word_t m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic is_reg(logic [7:0] a, logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic in_region(logic [7:0] a, logic [2:0] r);
        return (a[7:5] == r) && (int'(a[4:2]) < NUM_MOD);
    endfunction

    // Write channel state
    logic aw_hold_reg, aw_hold_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_hold_reg, w_hold_next;
    cntarr_word_t w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic do_wr, wr_map;
    // Read channel state
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    cntarr_word_t rdata_reg, rdata_next;
    cntarr_word_t rd_val;
    logic rd_map;
    // Core state
    logic [7:0] mode_reg, mode_next;
    logic run_reg, run_next;
    logic ovf_reg, ovf_next;
    logic [NUM_MOD-1:0] mflag_reg, mflag_next;
    cntarr_cnt_t cnt_reg, cnt_next;
    logic cnt_upd_reg, cnt_upd_next;
    logic [2:0] div_reg, div_next;
    logic irq_reg, irq_next;
    logic wdt_reg, wdt_next;
    cntarr_mode_s chmode_reg [NUM_MOD], chmode_next [NUM_MOD];
    // Derived
    logic [1:0] src;
    logic count_en, tick, ovf_evt, cnt_wr;
    cntarr_word_t ctrl_word, stat_word;
    logic [NUM_MOD-1:0] hit_vec, set_vec, ie_vec, pin_vec, oe_vec;
    logic [NUM_MOD-1:0] rise_vec, fall_vec;
    logic ext_fall, ext_rise;
    cntarr_cnt_t cmp_val [NUM_MOD];

    cntarr_ch_if ch_if [NUM_MOD] ();

    cntarr_sync #(
        .W(NUM_MOD + 1)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({ext_count_input, module_pin_in}),
        .rise({ext_rise, rise_vec}),
        .fall({ext_fall, fall_vec})
    );

    // AXI4-Lite write: aw and w in either order
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_map = is_reg(aw_addr_reg, `CNTARR_OFF_MODE)
        || is_reg(aw_addr_reg, `CNTARR_OFF_CTRL)
        || is_reg(aw_addr_reg, `CNTARR_OFF_COUNT)
        || in_region(aw_addr_reg, `CNTARR_REGION_MMODE)
        || in_region(aw_addr_reg, `CNTARR_REGION_MCMP);

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next = w_hold_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_map ? `CNTARR_RESP_OKAY : `CNTARR_RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `CNTARR_RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg <= w_hold_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // AXI4-Lite read: one cycle from address to data
    always_comb begin
        ctrl_word = '0;
        ctrl_word[NUM_MOD-1:0] = mflag_reg;
        ctrl_word[`CNTARR_CTRL_RUN] = run_reg;
        ctrl_word[`CNTARR_CTRL_OVF] = ovf_reg;
        stat_word = '0;
        stat_word[NUM_MOD-1:0] = pin_vec;
        stat_word[`CNTARR_STAT_OE +: NUM_MOD] = oe_vec;
        stat_word[`CNTARR_STAT_EXT] = ext_count_claimed;
        rd_val = '0;
        rd_map = 1'b1;
        if (is_reg(s_axi_araddr, `CNTARR_OFF_MODE)) begin
            rd_val[7:0] = mode_reg;
        end else if (is_reg(s_axi_araddr, `CNTARR_OFF_CTRL)) begin
            rd_val = ctrl_word;
        end else if (is_reg(s_axi_araddr, `CNTARR_OFF_COUNT)) begin
            rd_val[15:0] = cnt_reg;
        end else if (is_reg(s_axi_araddr, `CNTARR_OFF_STATUS)) begin
            rd_val = stat_word;
        end else if (in_region(s_axi_araddr, `CNTARR_REGION_MMODE)) begin
            rd_val[6:0] = chmode_reg[s_axi_araddr[4:2]];
        end else if (in_region(s_axi_araddr, `CNTARR_REGION_MCMP)) begin
            rd_val[15:0] = cmp_val[s_axi_araddr[4:2]];
        end else begin
            rd_map = 1'b0;
        end
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = rd_val;
            rresp_next = rd_map ? `CNTARR_RESP_OKAY : `CNTARR_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `CNTARR_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Time base
    assign src = mode_reg[`CNTARR_MODE_SRC_HI:`CNTARR_MODE_SRC_LO];
    assign count_en = run_reg
        && !(mode_reg[`CNTARR_MODE_IDLE] && idle_mode);
    assign cnt_wr = do_wr && is_reg(aw_addr_reg, `CNTARR_OFF_COUNT);
    // Ext pin assumed below clock/4
    assign ext_count_claimed = (src == `CNTARR_SRC_EXT);

    always_comb begin
        unique case (src)
            `CNTARR_SRC_DIV6: tick = count_en && div_reg == `CNTARR_DIV6_LAST;
            `CNTARR_SRC_DIV2: tick = count_en && div_reg[0];
            `CNTARR_SRC_TMR0: tick = count_en && timer0_ovf;
            `CNTARR_SRC_EXT: tick = count_en && ext_fall;
        endcase
    end

    assign ovf_evt = tick && !cnt_wr && (cnt_reg == 16'hFFFF);

    always_comb begin
        cntarr_word_t mw;
        mw = '0;
        div_next = div_reg;
        if (!count_en || div_reg == `CNTARR_DIV6_LAST) begin
            div_next = 3'h0;
        end else begin
            div_next = div_reg + 3'h1;
        end
        cnt_next = cnt_reg;
        cnt_upd_next = 1'b0;
        if (cnt_wr) begin
            mw = merge({16'h0000, cnt_reg}, w_data_reg, w_strb_reg);
            cnt_next = mw[15:0];
        end else if (tick) begin
            cnt_next = cnt_reg + 16'h0001;
            cnt_upd_next = 1'b1;
        end
        mode_next = mode_reg;
        run_next = run_reg;
        ovf_next = ovf_reg | ovf_evt;
        mflag_next = mflag_reg | set_vec;
        if (do_wr && is_reg(aw_addr_reg, `CNTARR_OFF_MODE)) begin
            mw = merge({24'h00_0000, mode_reg}, w_data_reg, w_strb_reg);
            mode_next = mw[7:0] & `CNTARR_MODE_MASK;
        end
        if (do_wr && is_reg(aw_addr_reg, `CNTARR_OFF_CTRL)) begin
            mw = merge(ctrl_word, w_data_reg, w_strb_reg);
            run_next = mw[`CNTARR_CTRL_RUN];
            // A flag raised in the same cycle survives the clear
            ovf_next = mw[`CNTARR_CTRL_OVF] | ovf_evt;
            mflag_next = mw[NUM_MOD-1:0] | set_vec;
        end
        for (int i = 0; i < NUM_MOD; i++) begin
            chmode_next[i] = chmode_reg[i];
            if (do_wr && in_region(aw_addr_reg, `CNTARR_REGION_MMODE)
                    && aw_addr_reg[4:2] == 3'(i)) begin
                mw = merge({25'h000_0000, chmode_reg[i]}, w_data_reg,
                    w_strb_reg);
                chmode_next[i] = cntarr_mode_s'(mw[6:0]);
            end
        end
        irq_next = (ovf_reg && mode_reg[`CNTARR_MODE_OVF_IE])
                || |(mflag_reg & ie_vec);
        wdt_next = mode_reg[`CNTARR_MODE_WDT]
                && hit_vec[`CNTARR_WDT_MOD];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= 3'h0;
            cnt_reg <= 16'h0000;
            cnt_upd_reg <= 1'b0;
            mode_reg <= `CNTARR_MODE_RST;
            run_reg <= 1'b0;
            ovf_reg <= 1'b0;
            mflag_reg <= '0;
            irq_reg <= 1'b0;
            wdt_reg <= 1'b0;
            for (int i = 0; i < NUM_MOD; i++) begin
                chmode_reg[i] <= '0;
            end
        end else begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            cnt_upd_reg <= cnt_upd_next;
            mode_reg <= mode_next;
            run_reg <= run_next;
            ovf_reg <= ovf_next;
            mflag_reg <= mflag_next;
            irq_reg <= irq_next;
            wdt_reg <= wdt_next;
            for (int i = 0; i < NUM_MOD; i++) begin
                chmode_reg[i] <= chmode_next[i];
            end
        end
    end

    assign irq = irq_reg;
    assign wdt_reset = wdt_reg;

    // Modules on the one shared counter
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        cntarr_word_t cw;
        assign cw = merge({16'h0000, cmp_val[g]}, w_data_reg, w_strb_reg);
        assign ch_if[g].cnt = cnt_reg;
        assign ch_if[g].cnt_upd = cnt_upd_reg;
        assign ch_if[g].mode = chmode_reg[g];
        assign ch_if[g].cmp_wr = do_wr
            && in_region(aw_addr_reg, `CNTARR_REGION_MCMP)
            && aw_addr_reg[4:2] == 3'(g);
        assign ch_if[g].cmp_wdata = cw[15:0];
        assign ch_if[g].edge_rise = rise_vec[g];
        assign ch_if[g].edge_fall = fall_vec[g];
        assign cmp_val[g] = ch_if[g].cmp_val;
        assign hit_vec[g] = ch_if[g].hit;
        assign set_vec[g] = ch_if[g].flag_set;
        assign pin_vec[g] = ch_if[g].pin_out;
        assign oe_vec[g] = ch_if[g].pin_oe;
        assign ie_vec[g] = chmode_reg[g].module_irq_enable;

        cntarr_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .bus(ch_if[g])
        );
    end

    assign module_pin_out = pin_vec;
    assign module_pin_oe = oe_vec;
endmodule
`default_nettype wire
